/* rtl/ocs_supervisor.sv */
// overcurrent alert supervisor: three current checks, fault actions,
// soft start, power good, alert timer and a config store that is never reloaded after reset.
// assumes iout/vout and the wishbone bus arrive on clk; all other pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module ocs_supervisor
#(
    parameter int SAMPLE_CYC  = ocs_pkg::SAMPLE_CYC,
    parameter int SS_CYC      = ocs_pkg::SS_CYC,
    parameter int SS_CHECK_CYC = ocs_pkg::SS_CHECK_CYC,
    parameter int RESTART_CYC = ocs_pkg::RESTART_CYC
)
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // wishbone slave
    input  wire ocs_pkg::ocs_wb_req_s wb_i,
    output var  logic [31:0]        wb_dat_o,
    output var  logic               wb_ack_o,
    // asynchronous pins
    input  wire logic               en_pin,
    input  wire logic               vin_ok_pin,
    input  wire logic               comp_trip_pin,
    input  wire logic               temp_warn_pin,
    input  wire logic               ramp_ok_pin,
    input  wire logic               scl_i,
    // converter samples on clk
    input  wire logic [15:0]        iout,
    input  wire logic [15:0]        vout,
    // power stage and open-drain outputs
    output var  logic               out_on_o,
    output var  logic               power_good_o,
    output var  logic               power_good_oe,
    output var  logic               fault_alert_o,
    output var  logic               fault_alert_oe,
    output var  logic               scl_o,
    output var  logic               scl_oe
);
    import ocs_pkg::*;

    function automatic logic [5:0] ocs_win(input logic [5:0] t);
        return (t == 6'h00) ? 6'h01 : t;
    endfunction : ocs_win

    function automatic logic [6:0] ocs_count(input logic [63:0] h,
                                             input logic [5:0]  w);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 64; i++)
            if (i < int'(w))
                c = c + 7'(h[i]);
        return c;
    endfunction : ocs_count

    ////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0]        rst_ff_r;
    logic [N_PINS-1:0] s1_r;
    logic [N_PINS-1:0] s2_r;
    logic [N_PINS-1:0] s3_r;
    logic [N_PINS-1:0] flt_r;
    logic              en_prev_r;
    wire               rst_s_n = rst_ff_r[1];

    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            rst_ff_r <= 2'b00;
        else
            rst_ff_r <= {rst_ff_r[0], 1'b1};

    wire [N_PINS-1:0] pin_raw = {scl_i, ramp_ok_pin, temp_warn_pin,
                                 comp_trip_pin, vin_ok_pin, en_pin};
    // a level counts once the second and third stages agree
    wire [N_PINS-1:0] flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
    wire en_f   = flt_r[PIN_EN];
    wire vin_f  = flt_r[PIN_VIN];
    wire comp_f = flt_r[PIN_COMP];   // 1 us = 40 clocks, never missed
    wire temp_f = flt_r[PIN_TEMP];
    wire ramp_f = flt_r[PIN_RAMP];
    wire scl_f  = flt_r[PIN_SCL];    // 400 kHz max is slow to clk

    always_ff @(posedge clk or negedge rst_s_n)
        if (!rst_s_n)
        begin
            s1_r      <= '0;
            s2_r      <= '0;
            s3_r      <= '0;
            flt_r     <= '0;
            en_prev_r <= 1'b0;
        end
        else
        begin
            s1_r      <= pin_raw;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            flt_r     <= flt_nxt;
            en_prev_r <= en_f;
        end

    ////////////////////////////////////////////////////////////////////
    // sample tick, average and timed checks
    ocs_state_e  state_r;
    ocs_state_e  state_nxt;
    ocs_cfg_s    cfg_r;
    ocs_cfg_s    cfg_nxt;
    logic [19:0] tick_cnt_r;
    logic [15:0] smp_r [3];
    logic [63:0] hist_r;
    logic [31:0] telem_r;

    wire        tick_w  = tick_cnt_r == 20'(SAMPLE_CYC - 1);
    wire        run_w   = state_r == ST_RAMP || state_r == ST_ON;
    wire [17:0] sum_w   = 18'(iout) + 18'(smp_r[0]) + 18'(smp_r[1])
                        + 18'(smp_r[2]);
    wire        avg_over_w = sum_w[17:2] > cfg_r.fault_thr;
    wire        cur_over_w = iout > cfg_r.warn_thr;
    wire [5:0]  win_w   = ocs_win(cfg_r.warn_time);
    wire [63:0] hist_nxt = {hist_r[62:0], cur_over_w};
    wire [6:0]  over_cnt_w = ocs_count(hist_nxt, win_w);
    wire        timed_over_w = {over_cnt_w, 1'b0} > {2'b00, win_w};
    wire        ev_avg   = tick_w && avg_over_w && run_w;
    wire        ev_timed = tick_w && timed_over_w && run_w;

    always_ff @(posedge clk or negedge rst_s_n)
        if (!rst_s_n)
        begin
            tick_cnt_r <= '0;
            smp_r[0]   <= '0;
            smp_r[1]   <= '0;
            smp_r[2]   <= '0;
            hist_r     <= '0;
            telem_r    <= '0;
        end
        else
        begin
            tick_cnt_r <= tick_w ? 20'h00000 : tick_cnt_r + 20'h00001;
            if (tick_w)
            begin
                smp_r[0] <= iout;
                smp_r[1] <= smp_r[0];
                smp_r[2] <= smp_r[1];
                hist_r   <= hist_nxt;
                telem_r  <= {vout, iout};
            end
        end

    ////////////////////////////////////////////////////////////////////
    // output state machine and fault actions
    logic [19:0] tmr_r;
    logic [19:0] tmr_nxt;
    wire short_w  = state_r == ST_RAMP && !ramp_f
                 && tmr_r >= 20'(SS_CHECK_CYC);
    wire oc_ev    = ev_avg || ev_timed;
    wire init_last = state_r == ST_INIT && tmr_r == 20'(INIT_CYC - 1);

    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r + 20'h00001;
        case (state_r)
            ST_INIT:    if (init_last) state_nxt = ST_OFF;
            ST_OFF:     if (en_f && vin_f) state_nxt = ST_RAMP;
            ST_RAMP:    if (tmr_r == 20'(SS_CYC - 1)) state_nxt = ST_ON;
            ST_ON:      state_nxt = ST_ON;
            ST_LATCHED: if (!en_f) state_nxt = ST_OFF;
            ST_WAIT:
                if (tmr_r == 20'(RESTART_CYC - 1))
                    state_nxt = en_f ? ST_RAMP : ST_OFF;
            default:    state_nxt = ST_OFF;
        endcase
        if (run_w)
        begin
            if (!en_f || !vin_f)
                state_nxt = ST_OFF;
            if (comp_f || short_w)
                state_nxt = ST_LATCHED;
            else if (oc_ev && cfg_r.action == ACT_RESTART)
                state_nxt = ST_WAIT;
            else if (oc_ev && cfg_r.action != ACT_IGNORE)
                state_nxt = ST_LATCHED;
        end
        if (state_nxt != state_r)
            tmr_nxt = 20'h00000;
    end

    ////////////////////////////////////////////////////////////////////
    // register bus decode
    logic        ack_r;
    logic [7:0]  sts_r;
    logic [5:0]  used_r;
    logic [4:0]  busy_r;
    logic        pg_oe_r;
    logic        pg_lock_r;
    ocs_cfg_s    nvm_mem [NVM_SLOTS];

    wire        acc_w    = wb_i.cyc && wb_i.stb && !ack_r;
    wire        wr_ok    = acc_w && wb_i.we && wb_i.sel[0]
                        && state_r != ST_INIT;
    wire        clr_wr   = wr_ok && wb_i.adr == ADR_CLEAR;
    wire        store_wr = wr_ok && wb_i.adr == ADR_STORE
                        && busy_r == 5'h00;
    wire        slot_ok  = used_r < 6'(NVM_SLOTS);
    wire [5:0]  left_w   = 6'(NVM_SLOTS) - used_r;
    wire [7:0]  sts_set  = {2'b00, tick_w && cur_over_w && run_w, temp_f,
                            short_w, ev_timed, ev_avg, comp_f};
    wire [7:0]  sts_rd   = {1'b0, !pg_oe_r, sts_r[5:0]};
    // codes double as word indices, no packet error
    wire [31:0] rd_w =
        (wb_i.adr == ADR_STORES_LEFT) ? {26'h0, left_w} :
        (wb_i.adr == ADR_FAULT_THR)   ? {16'h0, cfg_r.fault_thr} :
        (wb_i.adr == ADR_WARN_THR)    ? {16'h0, cfg_r.warn_thr} :
        (wb_i.adr == ADR_WARN_TIME)   ? {26'h0, cfg_r.warn_time} :
        (wb_i.adr == ADR_ACTION)      ? {30'h0, cfg_r.action} :
        (wb_i.adr == ADR_STATUS)      ? {24'h0, sts_rd} :
        (wb_i.adr == ADR_TELEM)       ? telem_r : 32'h0;

    always_comb
    begin
        cfg_nxt = cfg_r;
        if (init_last)
            cfg_nxt = (used_r == 6'h00) ? CFG_RST
                    : nvm_mem[5'(used_r - 6'h01)];
        if (wr_ok && wb_i.adr == ADR_FAULT_THR)
            cfg_nxt.fault_thr = wb_i.dat[15:0];
        if (wr_ok && wb_i.adr == ADR_WARN_THR)
            cfg_nxt.warn_thr = wb_i.dat[15:0];
        if (wr_ok && wb_i.adr == ADR_WARN_TIME)
            cfg_nxt.warn_time = wb_i.dat[5:0];
        if (wr_ok && wb_i.adr == ADR_ACTION)
            cfg_nxt.action = wb_i.dat[1:0];
    end

    // store slots keep their contents; only the slot count resets
    always_ff @(posedge clk)
        if (store_wr && slot_ok)
            nvm_mem[used_r[4:0]] <= cfg_r;

    ////////////////////////////////////////////////////////////////////
    // registered state, outputs, power good and alert
    logic       alert_r;
    logic [5:0] alert_tmr_r;
    logic       out_on_r;
    logic       scl_oe_r;
    logic       od_low_r;
    logic [31:0] dat_r;
    wire warn_now = temp_f || cur_over_w || (|sts_r[3:0]);
    wire en_tgl   = en_f != en_prev_r;

    always_ff @(posedge clk or negedge rst_s_n)
        if (!rst_s_n)
        begin
            state_r     <= ST_INIT;
            tmr_r       <= '0;
            cfg_r       <= CFG_RST;
            ack_r       <= 1'b0;
            dat_r       <= '0;
            sts_r       <= '0;
            used_r      <= '0;
            busy_r      <= '0;
            pg_oe_r     <= 1'b1;
            pg_lock_r   <= 1'b0;
            alert_r     <= 1'b0;
            alert_tmr_r <= '0;
            out_on_r    <= 1'b0;
            scl_oe_r    <= 1'b0;
            od_low_r    <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            tmr_r    <= tmr_nxt;
            cfg_r    <= cfg_nxt;
            ack_r    <= acc_w;
            if (acc_w)
                dat_r <= rd_w;
            // a new event wins over a clear in the same cycle
            sts_r    <= (clr_wr ? 8'h00 : sts_r) | sts_set;
            if (store_wr && slot_ok)
                used_r <= used_r + 6'h01;
            busy_r   <= store_wr ? 5'(STORE_CYC)
                      : (busy_r != 5'h00) ? busy_r - 5'h01 : 5'h00;
            // hold the serial clock low while a store is busy, once the line has been seen low
            scl_oe_r <= busy_r != 5'h00 && (!scl_f || scl_oe_r);
            out_on_r <= state_nxt == ST_RAMP || state_nxt == ST_ON;
            if (state_r == ST_OFF && !vin_f && en_tgl)
                pg_lock_r <= 1'b1;
            pg_oe_r  <= !(state_r == ST_ON && !pg_lock_r);
            od_low_r <= 1'b0;
            if (!alert_r && warn_now)
            begin
                alert_r     <= 1'b1;
                alert_tmr_r <= win_w;
            end
            else if (alert_r && tick_w)
            begin
                if (alert_tmr_r > 6'h01)
                    alert_tmr_r <= alert_tmr_r - 6'h01;
                else if (warn_now)
                    alert_tmr_r <= win_w;
                else
                    alert_r <= 1'b0;
            end
        end

    assign wb_dat_o       = dat_r;
    assign wb_ack_o       = ack_r;
    assign out_on_o       = out_on_r;
    assign power_good_o   = od_low_r;
    assign power_good_oe  = pg_oe_r;
    assign fault_alert_o  = od_low_r;
    assign fault_alert_oe = alert_r;
    assign scl_o          = od_low_r;
    assign scl_oe         = scl_oe_r;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s_n);

    sequence s_enter_wait;
        state_r != ST_WAIT ##1 state_r == ST_WAIT;
    endsequence

    a_avg_trip: assert property (ev_avg |=> sts_r[SB_AVG])
        else $error("average trip not recorded");
    a_timed_trip: assert property (ev_timed |=> sts_r[SB_TIMED])
        else $error("timed trip not recorded");
    a_comp_latch: assert property (run_w && comp_f |=>
        state_r == ST_LATCHED && !out_on_r)
        else $error("comparator trip did not latch off");
    a_latch_hold: assert property (state_r == ST_LATCHED && en_f
        |=> state_r == ST_LATCHED)
        else $error("latched state left without enable cycle");
    a_pg_not_on: assert property (state_r != ST_ON |=> pg_oe_r)
        else $error("power good released before soft start done");
    a_pg_lock: assert property (pg_lock_r |=> pg_oe_r [*4])
        else $error("power good released while locked");
    a_alert_set: assert property (!alert_r && warn_now
        |=> fault_alert_oe)
        else $error("alert not asserted on warning");
    a_init_block: assert property (state_r == ST_INIT && !init_last
        |=> $stable(cfg_r))
        else $error("config changed during initialisation");
    a_store_count: assert property (store_wr && slot_ok
        |=> used_r == $past(used_r) + 6'h01)
        else $error("store did not take a fresh slot");
    a_clear_status: assert property (clr_wr && sts_set == 8'h00
        |=> sts_r == 8'h00)
        else $error("status not cleared");
    a_restart_off: assert property (s_enter_wait |->
        (!out_on_r && state_r == ST_WAIT) [*8])
        else $error("restart delay cut short");

endmodule : ocs_supervisor

`default_nettype wire

/* rtl/ocs_pkg.sv */
// package for the overcurrent alert supervisor: timing, offsets,
// reset values, status layout, configuration and bus carriers.
// assumes a 40 MHz core clock and a classic wishbone register bus.
package ocs_pkg;

    // clock and timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
    localparam int SAMPLE_US    = 250;
    localparam int SAMPLE_CYC   = SAMPLE_US * CYC_PER_US;
    localparam int SS_US        = 2000;
    localparam int SS_CYC       = SS_US * CYC_PER_US;
    localparam int SS_CHECK_US  = 100;
    localparam int SS_CHECK_CYC = SS_CHECK_US * CYC_PER_US;
    localparam int RESTART_US   = 5000;
    localparam int RESTART_CYC  = RESTART_US * CYC_PER_US;
    localparam int INIT_CYC     = 32;
    localparam int STORE_CYC    = 16;

    // persistent store
    localparam int NVM_SLOTS = 32;

    // command codes and register byte addresses
    localparam logic [7:0]  CMD_CLEAR       = 8'h03;
    localparam logic [7:0]  CMD_STORES_LEFT = 8'hcf;
    localparam logic [7:0]  CMD_STORE       = 8'hd6;
    localparam logic [11:0] ADR_CLEAR       = {2'b00, CMD_CLEAR, 2'b00};
    localparam logic [11:0] ADR_STORES_LEFT = {2'b00, CMD_STORES_LEFT, 2'b00};
    localparam logic [11:0] ADR_STORE       = {2'b00, CMD_STORE, 2'b00};
    localparam logic [11:0] ADR_FAULT_THR   = 12'h400;
    localparam logic [11:0] ADR_WARN_THR    = 12'h404;
    localparam logic [11:0] ADR_WARN_TIME   = 12'h408;
    localparam logic [11:0] ADR_ACTION      = 12'h40c;
    localparam logic [11:0] ADR_STATUS      = 12'h410;
    localparam logic [11:0] ADR_TELEM       = 12'h414;

    // fault action codes
    localparam logic [1:0] ACT_LATCH   = 2'h1;
    localparam logic [1:0] ACT_IGNORE  = 2'h2;
    localparam logic [1:0] ACT_RESTART = 2'h3;

    // reset values of the working configuration
    localparam logic [15:0] FAULT_THR_RST = 16'h0c00;
    localparam logic [15:0] WARN_THR_RST  = 16'h0a00;
    localparam logic [5:0]  WARN_TIME_RST = 6'h28;

    // status bit positions
    localparam int SB_COMP  = 0;
    localparam int SB_AVG   = 1;
    localparam int SB_TIMED = 2;
    localparam int SB_SHORT = 3;
    localparam int SB_WARNING_WINDOW = 4;
    localparam int SB_CWARN = 5;
    localparam int SB_PG    = 6;

    // synchronised pin indices
    localparam int PIN_EN   = 0;
    localparam int PIN_VIN  = 1;
    localparam int PIN_COMP = 2;
    localparam int PIN_TEMP = 3;
    localparam int PIN_RAMP = 4;
    localparam int PIN_SCL  = 5;
    localparam int N_PINS   = 6;

    typedef struct packed {
        logic [15:0] fault_thr;
        logic [15:0] warn_thr;
        logic [5:0]  warn_time;
        logic [1:0]  action;
    } ocs_cfg_s;

    localparam ocs_cfg_s CFG_RST = '{FAULT_THR_RST, WARN_THR_RST,
                                     WARN_TIME_RST, ACT_LATCH};

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ocs_wb_req_s;

    typedef enum logic [2:0] {
        ST_INIT, ST_OFF, ST_RAMP, ST_ON, ST_LATCHED, ST_WAIT
    } ocs_state_e;

endpackage : ocs_pkg

/* verification/ocs_host_model.sv */
// serial host model: one byte frame of clocks with stretching honoured.
// assumes a pull-up on the clock line; device pulls low via scl_oe.
`timescale 1ns/100ps
`default_nettype none

module ocs_host_model
(
    // frame request and device pull-down
    input  wire logic go,
    input  wire logic scl_oe,
    // wired clock line and stretch count
    output var  logic scl_line,
    output var  int   stretched
);
    logic drv = 1'b1;

    // open-drain line with pull-up; idles high between frames
    assign scl_line = drv & ~scl_oe;

    initial stretched = 0;

    ////////////////////////////////////////////////////////////////////
    // 9 clocks per byte, no extra check byte
    always @(posedge go)
    begin
        repeat (9)
        begin
            #100 drv = 1'b0;
            #100 drv = 1'b1;
            // the device reacts through its synchroniser, so look later
            #40;
            // wait while the device holds the clock low
            while (!scl_line)
            begin
                #25 stretched++;
            end
            #60;
        end
    end
endmodule : ocs_host_model
`default_nettype wire

/* verification/ocs_supervisor_bench.sv */
// bench for the supervisor: wishbone master and scenario tasks.
// assumes the host model on the serial clock and shortened timing.
`timescale 1ns/100ps
`default_nettype none

module ocs_supervisor_bench;
    import ocs_pkg::*;
    logic        clk = 0, rst_n = 0, en = 0, vin = 1, comp = 0, temp = 0;
    logic        ramp = 1;
    logic [2:0]  od;
    logic        go = 0, ack, out_on, pg_oe, al_oe, scl_oe, scl_line;
    logic [15:0] iout = '0;
    logic [31:0] rd, wb_dat;
    ocs_wb_req_s wb = '0;
    int          errors = 0, samples_checked = 0, stretched;

    initial forever #12.5 clk = ~clk;

    ocs_supervisor #(.SAMPLE_CYC(20), .SS_CYC(64), .SS_CHECK_CYC(16),
        .RESTART_CYC(16))
    ocs_supervisor_inst (.clk(clk), .rst_n(rst_n), .wb_i(wb),
        .wb_dat_o(wb_dat), .wb_ack_o(ack), .en_pin(en), .vin_ok_pin(vin),
        .comp_trip_pin(comp), .temp_warn_pin(temp), .ramp_ok_pin(ramp),
        .scl_i(scl_line), .iout(iout), .vout(16'h0300), .out_on_o(out_on),
        .power_good_o(od[0]), .power_good_oe(pg_oe),
        .fault_alert_o(od[1]), .fault_alert_oe(al_oe), .scl_o(od[2]),
        .scl_oe(scl_oe));

    ocs_host_model ocs_host_model_inst (.go(go), .scl_oe(scl_oe),
        .scl_line(scl_line), .stretched(stretched));

    ////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic wb_cycle(logic we, logic [11:0] adr, logic [31:0] d);
        wb <= '{1'b1, 1'b1, we, adr, 4'hf, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = wb_dat;
        wb <= '0;
        @(posedge clk);
    endtask : wb_cycle

    // wait for out_on (which 0) or pg_oe (which 1) to reach want
    task automatic wait_sig(bit which, logic want, int n);
        while ((which ? pg_oe : out_on) !== want && n > 0)
        begin
            @(posedge clk);
            n--;
        end
    endtask : wait_sig

    task automatic done(string name);
        $display("test %s done", name);
    endtask : done

    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [11:0] a [6];
        logic [31:0] e [6];
        a = '{ADR_FAULT_THR, ADR_WARN_THR, ADR_WARN_TIME, ADR_ACTION,
              ADR_STORES_LEFT, 12'h7f0};
        e = '{32'(FAULT_THR_RST), 32'(WARN_THR_RST), 32'(WARN_TIME_RST),
              32'(ACT_LATCH), 32'(NVM_SLOTS), 32'h0};
        for (int i = 0; i < 6; i++)
        begin
            wb_cycle(1'b0, a[i], 32'h0);
            check("reset_read", rd, e[i]);
        end
        done("reset");
    endtask : t_reset

    task automatic t_power_good;
        en <= 1'b1;
        wait_sig(0, 1'b1, 50);
        check("pg_in_ramp", 32'(pg_oe), 32'h1);
        wait_sig(1, 1'b0, 300);
        check("pg_after_ramp", 32'(pg_oe), 32'h0);
        wb_cycle(1'b0, ADR_STATUS, 32'h0);
        check("pg_flag", 32'(rd[SB_PG]), 32'h1);
        done("power_good");
    endtask : t_power_good

    task automatic t_comparator;
        wb_cycle(1'b1, ADR_ACTION, 32'(ACT_IGNORE));
        comp <= 1'b1;
        step(40);
        comp <= 1'b0;
        wait_sig(0, 1'b0, 20);
        check("comp_off", 32'(out_on), 32'h0);
        step(100);
        check("comp_latched", 32'(out_on), 32'h0);
        check("comp_alert", 32'(al_oe), 32'h1);
        en <= 1'b0;
        step(10);
        en <= 1'b1;
        wait_sig(0, 1'b1, 300);
        check("reenable", 32'(out_on), 32'h1);
        wb_cycle(1'b0, ADR_STATUS, 32'h0);
        check("comp_sticky", 32'(rd[SB_COMP]), 32'h1);
        wb_cycle(1'b1, ADR_CLEAR, 32'h0);
        wb_cycle(1'b0, ADR_STATUS, 32'h0);
        check("comp_cleared", 32'(rd[SB_COMP]), 32'h0);
        done("comparator");
    endtask : t_comparator

    task automatic t_restart;
        wb_cycle(1'b1, ADR_ACTION, 32'(ACT_RESTART));
        wait_sig(1, 1'b0, 300);
        check("load_after_pg", 32'(pg_oe), 32'h0);
        iout <= 16'h0d00;
        wait_sig(0, 1'b0, 300);
        check("avg_off", 32'(out_on), 32'h0);
        iout <= 16'h0000;
        step(10);
        check("restart_wait", 32'(out_on), 32'h0);
        wb_cycle(1'b0, ADR_STATUS, 32'h0);
        check("avg_flag", 32'(rd[SB_AVG]), 32'h1);
        wait_sig(0, 1'b1, 400);
        check("restart_on", 32'(out_on), 32'h1);
        done("restart");
    endtask : t_restart

    task automatic t_store;
        wb_cycle(1'b1, ADR_STORE, 32'h0);
        go <= 1'b1;
        step(120);
        go <= 1'b0;
        check("stretch", 32'(stretched != 0), 32'h1);
        wb_cycle(1'b0, ADR_STORES_LEFT, 32'h0);
        check("stores_left", rd, 32'(NVM_SLOTS - 1));
        done("store");
    endtask : t_store

    task automatic t_alert;
        wb_cycle(1'b1, ADR_WARN_TIME, 32'h2);
        wb_cycle(1'b1, ADR_CLEAR, 32'h0);
        step(1000);
        check("alert_idle", 32'(al_oe), 32'h0);
        temp <= 1'b1;
        step(8);
        check("alert_temp", 32'(al_oe), 32'h1);
        check("od_low", 32'(od), 32'h0);
        step(100);
        check("alert_held", 32'(al_oe), 32'h1);
        temp <= 1'b0;
        wb_cycle(1'b1, ADR_CLEAR, 32'h0);
        step(200);
        check("alert_release", 32'(al_oe), 32'h0);
        done("alert");
    endtask : t_alert

    task automatic t_short;
        ramp <= 1'b0;
        en <= 1'b0;
        step(10);
        en <= 1'b1;
        wait_sig(0, 1'b1, 50);
        wait_sig(0, 1'b0, 50);
        check("short_off", 32'(out_on), 32'h0);
        wb_cycle(1'b0, ADR_STATUS, 32'h0);
        check("short_flag", 32'(rd[SB_SHORT]), 32'h1);
        ramp <= 1'b1;
        done("short");
    endtask : t_short

    task automatic t_lock;
        en <= 1'b0;
        vin <= 1'b0;
        step(10);
        en <= 1'b1;
        step(10);
        en <= 1'b0;
        step(10);
        en <= 1'b1;
        step(10);
        vin <= 1'b1;
        wait_sig(0, 1'b1, 300);
        step(200);
        check("pg_locked", 32'(pg_oe), 32'h1);
        done("lock");
    endtask : t_lock

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        step(12);
        rst_n <= 1'b1;
        step(5);
        wb_cycle(1'b1, ADR_FAULT_THR, 32'h1234);
        step(40);
        t_reset();
        t_power_good();
        t_comparator();
        t_restart();
        t_store();
        t_alert();
        t_short();
        t_lock();
        conclude();
    end

    initial
    begin
        #500_000;
        errors++;
        conclude();
    end
endmodule : ocs_supervisor_bench
`default_nettype wire
